/* nco_params.svh */
// What this block does
// R1 - Accumulator spans upper, high and low bytes; only 20 bits are implemented.
// R2 - Upper accumulator byte bits 7 to 4 read as zero.
// R3 - Accumulator advances on the oscillator clock, independent of the bus.
// R4 - Software must not write accumulator bytes while the oscillator runs.
// R5 - Increment low byte holds bits 7:0, high byte bits 15:8.
// R6 - Shadow increment loads on first source clock falling edge after low write.
// R7 - Software should write upper and high increment bytes before low byte.
// R8 - Increment upper byte holds bits 19:16 in bits 3:0; rest read zero.
// R9 - Reset clears the accumulator and sets increment and shadow to one.
`ifndef NCO_PARAMS_SVH
`define NCO_PARAMS_SVH

`define NCO_OFS_ACC_LOW    8'h00
`define NCO_OFS_ACC_HIGH   8'h04
`define NCO_OFS_ACC_UPPER  8'h08
`define NCO_OFS_STEP_LOW   8'h0C
`define NCO_OFS_STEP_HIGH  8'h10
`define NCO_OFS_STEP_UPPER 8'h14
`define NCO_OFS_CONTROL    8'h18

`define NCO_RUN_BIT        0
`define NCO_PHASE_WIDTH    20
`define NCO_UPPER_WIDTH    4

`define NCO_ACC_RESET      20'h00000
`define NCO_STEP_RESET     20'h00001
`define NCO_CONTROL_RESET  1'h0

`define NCO_RESP_OKAY      2'h0
`define NCO_RESP_SLVERR    2'h2

`endif

/* nco_pkg.sv */
`default_nettype none
package nco_pkg;
  `include "nco_params.svh"

  // One phase word, accumulator or increment.
  typedef logic [`NCO_PHASE_WIDTH-1:0] phase_type;

  // Decoded register selection.
  typedef enum {
    SEL_ACC_LOW,
    SEL_ACC_HIGH,
    SEL_ACC_UPPER,
    SEL_STEP_LOW,
    SEL_STEP_HIGH,
    SEL_STEP_UPPER,
    SEL_CONTROL,
    SEL_NONE
  } reg_sel_type;
endpackage
`default_nettype wire

/* nco_sync.sv */
`default_nettype none
module nco_sync (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stage1_r;
  logic stage1_nxt;
  logic stage2_nxt;

  // The first stage feeds only the second, so metastability cannot spread.
  always_comb begin
    stage1_nxt = asyncIn;
    stage2_nxt = stage1_r;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stage1_r <= 1'h0;
      syncOut  <= 1'h0;
    end else begin
      stage1_r <= stage1_nxt;
      syncOut  <= stage2_nxt;
    end
  end
endmodule
`default_nettype wire

/* nco_phase_accumulator_regs.sv */
`default_nettype none
`include "nco_params.svh"
module nco_phase_accumulator_regs
  import nco_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  oscillator_source_clock,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       overflowPulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Source clock synchronisation and edge detection.

  logic srcSync;
  logic srcPrev_r;
  logic srcPrev_nxt;
  logic srcRise;
  logic srcFall;

  nco_sync u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .asyncIn  (oscillator_source_clock),
    .syncOut  (srcSync)
  );

  // Edges are seen on the synchronised level, so the source must stay below
  // half the core clock rate or edges are lost.
  always_comb begin
    srcPrev_nxt = srcSync;
    srcRise     = srcSync & ~srcPrev_r;
    srcFall     = ~srcSync & srcPrev_r;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      srcPrev_r <= 1'h0;
    end else begin
      srcPrev_r <= srcPrev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by the read and write paths.

  function automatic reg_sel_type decode(input logic [ADDR_WIDTH-1:0] addr);
    logic [7:0] a;
    a = 8'(addr) & 8'hFC;
    case (a)
      `NCO_OFS_ACC_LOW:    decode = SEL_ACC_LOW;
      `NCO_OFS_ACC_HIGH:   decode = SEL_ACC_HIGH;
      `NCO_OFS_ACC_UPPER:  decode = SEL_ACC_UPPER;
      `NCO_OFS_STEP_LOW:   decode = SEL_STEP_LOW;
      `NCO_OFS_STEP_HIGH:  decode = SEL_STEP_HIGH;
      `NCO_OFS_STEP_UPPER: decode = SEL_STEP_UPPER;
      `NCO_OFS_CONTROL:    decode = SEL_CONTROL;
      default:             decode = SEL_NONE;
    endcase
    if (addr > ADDR_WIDTH'(8'hFC)) begin
      decode = SEL_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel capture. Address and data are taken independently.

  logic                  awHeld_r;
  logic                  awHeld_nxt;
  logic [ADDR_WIDTH-1:0] awAddr_r;
  logic [ADDR_WIDTH-1:0] awAddr_nxt;
  logic                  wHeld_r;
  logic                  wHeld_nxt;
  logic [7:0]            wByte_r;
  logic [7:0]            wByte_nxt;
  logic                  wLane_r;
  logic                  wLane_nxt;
  logic                  awready_nxt;
  logic                  wready_nxt;
  logic                  bvalid_nxt;
  logic [1:0]            bresp_nxt;
  logic                  doWrite;
  reg_sel_type           wSel;

  // The write commits one cycle after both halves are held and no response
  // is pending; the registers below consume doWrite and wSel.
  always_comb begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt  = wHeld_r;
    wByte_nxt  = wByte_r;
    wLane_nxt  = wLane_r;
    bvalid_nxt = s_axi_bvalid;
    bresp_nxt  = s_axi_bresp;
    doWrite    = awHeld_r & wHeld_r & ~s_axi_bvalid;
    wSel       = decode(awAddr_r);
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'h0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      awHeld_nxt = 1'h1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHeld_nxt = 1'h1;
      wByte_nxt = s_axi_wdata[7:0];
      wLane_nxt = s_axi_wstrb[0];
    end
    if (doWrite) begin
      awHeld_nxt = 1'h0;
      wHeld_nxt  = 1'h0;
      bvalid_nxt = 1'h1;
      bresp_nxt  = (wSel == SEL_NONE) ? `NCO_RESP_SLVERR : `NCO_RESP_OKAY;
    end
    awready_nxt = ~awHeld_nxt;
    wready_nxt  = ~wHeld_nxt;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      awHeld_r      <= 1'h0;
      awAddr_r      <= '0;
      wHeld_r       <= 1'h0;
      wByte_r       <= 8'h00;
      wLane_r       <= 1'h0;
      s_axi_awready <= 1'h0;
      s_axi_wready  <= 1'h0;
      s_axi_bvalid  <= 1'h0;
      s_axi_bresp   <= `NCO_RESP_OKAY;
    end else begin
      awHeld_r      <= awHeld_nxt;
      awAddr_r      <= awAddr_nxt;
      wHeld_r       <= wHeld_nxt;
      wByte_r       <= wByte_nxt;
      wLane_r       <= wLane_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready  <= wready_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator state: accumulator, increment bytes, shadow and run control.

  phase_type  acc_r;
  phase_type  acc_nxt;
  phase_type  step_r;
  phase_type  step_nxt;
  phase_type  shadow_r;
  phase_type  shadow_nxt;
  logic       loadPending_r;
  logic       loadPending_nxt;
  logic       run_r;
  logic       run_nxt;
  logic       overflow_nxt;
  logic       byteWrite;
  logic [20:0] sum;

  // Software writes take priority over an advance in the same cycle; writing
  // the accumulator while running gives undefined phase by contract.
  always_comb begin
    byteWrite       = doWrite & wLane_r;
    acc_nxt         = acc_r;
    step_nxt        = step_r;
    run_nxt         = run_r;
    shadow_nxt      = shadow_r;
    overflow_nxt    = 1'h0;
    sum             = {1'h0, acc_r} + {1'h0, shadow_r};
    if (run_r && srcRise) begin
      acc_nxt      = sum[19:0];        // R3
      overflow_nxt = sum[20];
    end
    if (byteWrite) begin
      case (wSel)
        SEL_ACC_LOW:    acc_nxt[7:0]   = wByte_r;                  // R1 R4
        SEL_ACC_HIGH:   acc_nxt[15:8]  = wByte_r;                  // R1 R4
        SEL_ACC_UPPER:  acc_nxt[19:16] = wByte_r[3:0];             // R1 R4
        SEL_STEP_LOW:   step_nxt[7:0]  = wByte_r;                  // R5
        SEL_STEP_HIGH:  step_nxt[15:8] = wByte_r;                  // R5
        SEL_STEP_UPPER: step_nxt[19:16] = wByte_r[3:0];            // R8
        SEL_CONTROL:    run_nxt        = wByte_r[`NCO_RUN_BIT];
        default:        run_nxt        = run_r;
      endcase
    end
    // A new low-byte write sets the pending flag even on a falling edge, so
    // the set always wins over the clear.
    loadPending_nxt = (byteWrite && wSel == SEL_STEP_LOW) | (loadPending_r & ~srcFall); // R6 R7
    if (loadPending_r && srcFall) begin
      shadow_nxt = step_nxt;           // R6
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      acc_r         <= `NCO_ACC_RESET;     // R9
      step_r        <= `NCO_STEP_RESET;    // R9
      shadow_r      <= `NCO_STEP_RESET;    // R9
      loadPending_r <= 1'h0;
      run_r         <= `NCO_CONTROL_RESET;
      overflowPulse <= 1'h0;
    end else begin
      acc_r         <= acc_nxt;
      step_r        <= step_nxt;
      shadow_r      <= shadow_nxt;
      loadPending_r <= loadPending_nxt;
      run_r         <= run_nxt;
      overflowPulse <= overflow_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel. Data return one cycle after the address is taken.

  logic        arready_nxt;
  logic        rvalid_nxt;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_nxt;
  reg_sel_type rSel;

  // Multi-byte reads are not atomic: the accumulator may step between reads.
  always_comb begin
    rvalid_nxt = s_axi_rvalid;
    rdata_nxt  = s_axi_rdata;
    rresp_nxt  = s_axi_rresp;
    rSel       = decode(s_axi_araddr);
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'h0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'h1;
      rresp_nxt  = `NCO_RESP_OKAY;
      case (rSel)
        SEL_ACC_LOW:    rdata_nxt = {24'h000000, acc_r[7:0]};
        SEL_ACC_HIGH:   rdata_nxt = {24'h000000, acc_r[15:8]};
        SEL_ACC_UPPER:  rdata_nxt = {28'h0000000, acc_r[19:16]};   // R2
        SEL_STEP_LOW:   rdata_nxt = {24'h000000, step_r[7:0]};
        SEL_STEP_HIGH:  rdata_nxt = {24'h000000, step_r[15:8]};
        SEL_STEP_UPPER: rdata_nxt = {28'h0000000, step_r[19:16]};  // R8
        SEL_CONTROL:    rdata_nxt = {31'h00000000, run_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = `NCO_RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid  <= 1'h0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `NCO_RESP_OKAY;
    end else begin
      s_axi_arready <= arready_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rdata   <= rdata_nxt;
      s_axi_rresp   <= rresp_nxt;
    end
  end
endmodule
`default_nettype wire

/* nco_phase_accumulator_regs_props.sv */
`default_nettype none
module nco_phase_accumulator_regs_props #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic                  core_clk,
  input wire logic                  nrst,
  input wire logic                  overflowPulse,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  // Bus handshakes keep the fixed latencies of this slave.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address accepted");
  a_w_block: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("second write data accepted");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read answer missing");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  // Every register is one byte, so the upper bits of a read stay clear.
  a_byte_only: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data above the byte");
  a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1B
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000) else $error("unmapped read");
  // A source rise is flagged for one core cycle only, so a carry is one pulse.
  a_ovf_single: assert property (overflowPulse |=> !overflowPulse)
    else $error("overflow pulse too long");
endmodule
bind nco_phase_accumulator_regs nco_phase_accumulator_regs_props #(
  .ADDR_WIDTH(ADDR_WIDTH)
) i_props (
  .core_clk, .nrst, .overflowPulse, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_araddr, .s_axi_rdata, .s_axi_rresp
);
`default_nettype wire

/* tb_nco_phase_accumulator_regs.sv */
`default_nettype none
module tb_nco_phase_accumulator_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 0, nrst = 0, oscillator_source_clock = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, overflowPulse;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          err_count = 0, n_tests = 0, ovf = 0;

  nco_phase_accumulator_regs i_dut (
    .core_clk, .nrst, .oscillator_source_clock, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .overflowPulse
  );

  // The clock toggles every half period of 12.5 ns.
  always #12.5 core_clk = ~core_clk;
  // Carries are counted so a missed or doubled wrap shows up.
  always @(posedge core_clk) if (overflowPulse === 1'b1) ovf <= ovf + 1;
  ////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A hung handshake is counted and ends the run at once.
  task automatic tmo(input int n);
    if (n >= 99) begin
      err_count++;
      results();
    end
  endtask

  // Address and data go out together; each is dropped once taken.
  task automatic wr(input logic [7:0] a, d, input logic [3:0] s = 4'h1,
                    input logic [1:0] r = 2'h0);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 99);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk("bresp", 32'(r), 32'(s_axi_bresp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 99);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(r), 32'(s_axi_rresp));
  endtask

  // Each level lasts four core cycles, well above the synchroniser limit.
  task automatic pulse(input int k);
    repeat (k) begin
      oscillator_source_clock <= 1'b1;
      repeat (4) @(posedge core_clk);
      oscillator_source_clock <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'(i == 3));
    wr(8'h14, 8'hFF);
    rd(8'h14, 32'h0F);
    // Accumulator bytes are written only while stopped.
    wr(8'h08, 8'hFF);
    rd(8'h08, 32'h0F);
    wr(8'h00, 8'hFF);
    wr(8'h04, 8'hFF);
    rd(8'h04, 32'hFF);
    wr(8'h14, 8'h00);
    wr(8'h10, 8'h01);
    wr(8'h0C, 8'h23);
    wr(8'h10, 8'h55, 4'h0);
    rd(8'h10, 32'h01);
    rd(8'h0C, 32'h23);
    wr(8'h40, 8'h12, 4'h1, 2'h2);
    rd(8'h40, 32'h0, 2'h2);
    // First rise still adds the old shadow of one, wrapping to zero.
    wr(8'h18, 8'h01);
    rd(8'h18, 32'h01);
    pulse(3);
    repeat (8) @(posedge core_clk);
    wr(8'h18, 8'h00);
    rd(8'h00, 32'h46);
    rd(8'h04, 32'h02);
    rd(8'h08, 32'h00);
    chk("overflow", 32'h1, 32'(ovf));
    // A second reset after the run is stopped must restore the accumulator and increment, the shadow too.
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'h00, 32'h00);
    rd(8'h0C, 32'h01);
    rd(8'h10, 32'h00);
    wr(8'h18, 8'h01);
    pulse(1);
    repeat (8) @(posedge core_clk);
    rd(8'h00, 32'h01);
    results();
  end
endmodule
`default_nettype wire
